// ===== rtl/uwk_regs.svh
// Register offsets, field positions, reset values and timing figures of the wake-up block
`ifndef UWK_REGS_SVH
`define UWK_REGS_SVH

`define UWK_OFS_CTRL 8'h00
`define UWK_OFS_TMO 8'h04
`define UWK_OFS_STAT 8'h08
`define UWK_OFS_DROP 8'h0c

`define UWK_CTRL_MODE_LSB 0
`define UWK_CTRL_MODE_MSB 1
`define UWK_CTRL_HWFC_BIT 2
`define UWK_CTRL_ABD_BIT 3

`define UWK_STAT_STATE_LSB 0
`define UWK_STAT_STATE_MSB 1
`define UWK_STAT_PORT_BIT 2
`define UWK_STAT_CTS_BIT 3
`define UWK_STAT_RTS_BIT 4
`define UWK_STAT_CALL_BIT 5

`define UWK_MODE_OFF 2'h0
`define UWK_MODE_CYCLIC 2'h1
`define UWK_MODE_RTS 2'h2

`define UWK_RST_MODE 2'h0
`define UWK_RST_HWFC 1'h0
`define UWK_RST_ABD 1'h0
`define UWK_RST_TMO 16'h07d0
`define UWK_TMO_MIN 16'h0028
`define UWK_TMO_MAX 16'hfde8

`define UWK_CHAR_CR 8'h0d

`define UWK_FRAME_US 4615
`define UWK_WAKE_MS 20
`define UWK_CLK_MHZ 200

`endif

// ===== rtl/uwk_pkg.sv
// Types shared by the wake-up block
`default_nettype none
package uwk_pkg;
  typedef enum logic [1:0] {UWK_IDLE, UWK_WAKING, UWK_ACTIVE} uwk_state_t;
  typedef logic [1:0] uwk_mode_t;
endpackage
`default_nettype wire

// ===== rtl/uwk_buf.sv
// Two-entry character buffer with registered outputs on both sides
`default_nettype none
module uwk_buf #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Filling side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // Draining side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  logic [W-1:0] slot1_r;
  logic full_r;
  logic push_w;
  logic pop_w;
  logic head_v_nxt;
  logic full_nxt;
  logic [W-1:0] head_nxt;
  logic [W-1:0] slot1_nxt;

  assign push_w = in_valid_i & in_ready_o;
  assign pop_w = out_valid_o & out_ready_i;
  // Head moves up from the second slot on a pop, new word lands where room is
  assign head_v_nxt = (pop_w ? full_r : out_valid_o) | push_w;
  assign full_nxt = pop_w ? (full_r & push_w) : (full_r | (push_w & out_valid_o));
  assign head_nxt = pop_w ? (full_r ? slot1_r : in_data_i) : (out_valid_o ? out_data_o : in_data_i);
  assign slot1_nxt = (push_w & ((pop_w & full_r) | (!pop_w & out_valid_o))) ? in_data_i : slot1_r;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_valid_o <= 1'h0;
      full_r <= 1'h0;
      in_ready_o <= 1'h0;
      out_data_o <= '0;
      slot1_r <= '0;
    end else begin
      out_valid_o <= head_v_nxt;
      full_r <= full_nxt;
      in_ready_o <= !full_nxt;
      out_data_o <= head_nxt;
      slot1_r <= slot1_nxt;
    end
  end
endmodule // uwk_buf
`default_nettype wire

// ===== rtl/uwk_top.sv
// Wake-up on received data and inactivity control of the main serial port
`include "uwk_regs.svh"
`default_nettype none
module uwk_top #(
  parameter int unsigned FRAME_CYC = `UWK_FRAME_US * `UWK_CLK_MHZ,
  parameter int unsigned WAKE_CYC = `UWK_WAKE_MS * 1000 * `UWK_CLK_MHZ
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Serial line and handshake
  input wire logic rxd_i,
  input wire logic rts_on_i,
  output logic cts_on_o,
  // Characters from the receiver
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic rx_ready_o,
  // Characters delivered to the module
  output logic dat_valid_o,
  output logic [7:0] dat_data_o,
  input wire logic dat_ready_i,
  // Module power control
  input wire logic call_active_i,
  output logic port_en_o,
  output logic module_active_o,
  output uwk_pkg::uwk_state_t pwr_state_o
);
  import uwk_pkg::*;

  localparam logic [31:0] FRAME_LAST = 32'(FRAME_CYC - 1);
  localparam logic [31:0] WAKE_LAST = 32'(WAKE_CYC - 1);

  function automatic logic [15:0] clamp_tmo(input logic [15:0] v);
    if (v < `UWK_TMO_MIN) begin
      clamp_tmo = `UWK_TMO_MIN;
    end else if (v > `UWK_TMO_MAX) begin
      clamp_tmo = `UWK_TMO_MAX;
    end else begin
      clamp_tmo = v;
    end
  endfunction

  // Configuration
  uwk_mode_t cfg_mode_r;
  logic cfg_hwfc_r;
  logic cfg_abd_r;
  logic [15:0] cfg_tmo_r;
  // Power state
  uwk_state_t state_r;
  uwk_state_t state_nxt;
  logic [31:0] wake_cnt_r;
  logic [31:0] frame_cnt_r;
  logic [15:0] frames_left_r;
  logic lead_pend_r;
  logic [7:0] drop_cnt_r;
  // Receive line synchroniser
  logic rxd_s1_r;
  logic rxd_s2_r;
  logic rxd_s3_r;

  // Register decode
  wire sel_ctrl = (reg_addr_i == `UWK_OFS_CTRL);
  wire sel_tmo = (reg_addr_i == `UWK_OFS_TMO);
  wire sel_stat = (reg_addr_i == `UWK_OFS_STAT);
  wire sel_drop = (reg_addr_i == `UWK_OFS_DROP);
  wire uwk_mode_t wr_mode = reg_wdata_i[`UWK_CTRL_MODE_MSB:`UWK_CTRL_MODE_LSB];
  // Reserved mode code keeps the previous setting
  wire uwk_mode_t new_mode = (wr_mode == 2'h3) ? cfg_mode_r : wr_mode;

  // Power-state decisions
  wire rise_w = rxd_s2_r & !rxd_s3_r;
  wire hold_on = (cfg_mode_r == `UWK_MODE_OFF) | call_active_i |
    ((cfg_mode_r == `UWK_MODE_RTS) & rts_on_i);
  wire tmo_done = (frames_left_r == 16'h0000);
  wire take_w = rx_valid_i & rx_ready_o;
  wire active_w = (state_r == UWK_ACTIVE);
  wire lead_drop = cfg_abd_r & lead_pend_r;
  // Nothing passes unless the port is fully awake
  wire push_w = take_w & active_w & port_en_o & !lead_drop;
  wire enter_act = !active_w & (state_nxt == UWK_ACTIVE);
  wire restart_tmo = enter_act | (take_w & active_w);
  wire port_en_nxt = (state_nxt == UWK_ACTIVE);
  // CTS reports the port state whenever it is meaningful to the host
  wire cts_follow = ((cfg_mode_r == `UWK_MODE_RTS) & !rts_on_i) |
    ((cfg_mode_r == `UWK_MODE_CYCLIC) & cfg_hwfc_r);
  wire cts_nxt = cts_follow ? port_en_nxt : 1'h1;

  wire [31:0] stat_w = {26'h0, call_active_i, rts_on_i, cts_on_o, port_en_o, state_r};
  wire [31:0] ctrl_w = {28'h0, cfg_abd_r, cfg_hwfc_r, cfg_mode_r};
  wire [31:0] rd_mux = sel_ctrl ? ctrl_w :
    sel_tmo ? {16'h0, cfg_tmo_r} :
    sel_stat ? stat_w :
    sel_drop ? {24'h0, drop_cnt_r} : 32'h0;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      UWK_IDLE: begin
        if (hold_on) begin
          state_nxt = UWK_ACTIVE;
        end else if (rise_w) begin
          state_nxt = UWK_WAKING;
        end
      end
      UWK_WAKING: begin
        if (hold_on || wake_cnt_r == 32'h0) begin
          state_nxt = UWK_ACTIVE;
        end
      end
      UWK_ACTIVE: begin
        if (!hold_on && tmo_done) begin
          state_nxt = UWK_IDLE;
        end
      end
      default: state_nxt = UWK_IDLE;
    endcase
  end

  // Synchroniser: first stage feeds only the second
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rxd_s1_r <= 1'h1;
      rxd_s2_r <= 1'h1;
      rxd_s3_r <= 1'h1;
    end else begin
      rxd_s1_r <= rxd_i;
      rxd_s2_r <= rxd_s1_r;
      rxd_s3_r <= rxd_s2_r;
    end
  end

  // Configuration writes
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_mode_r <= `UWK_RST_MODE;
      cfg_hwfc_r <= `UWK_RST_HWFC;
      cfg_abd_r <= `UWK_RST_ABD;
      cfg_tmo_r <= `UWK_RST_TMO;
    end else if (reg_wr_i && sel_ctrl) begin
      cfg_mode_r <= new_mode;
      // Flow control cannot coexist with the RTS-controlled setting
      cfg_hwfc_r <= reg_wdata_i[`UWK_CTRL_HWFC_BIT] & (new_mode != `UWK_MODE_RTS);
      cfg_abd_r <= reg_wdata_i[`UWK_CTRL_ABD_BIT];
    end else if (reg_wr_i && sel_tmo) begin
      cfg_tmo_r <= clamp_tmo(reg_wdata_i[15:0]);
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0;
    end
  end

  // Power state, wake timer and outputs
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= UWK_IDLE;
      wake_cnt_r <= 32'h0;
      port_en_o <= 1'h0;
      cts_on_o <= 1'h0;
      module_active_o <= 1'h0;
      pwr_state_o <= UWK_IDLE;
    end else begin
      state_r <= state_nxt;
      if (state_r == UWK_IDLE) begin
        wake_cnt_r <= WAKE_LAST;
      end else if (state_r == UWK_WAKING && wake_cnt_r != 32'h0) begin
        wake_cnt_r <= wake_cnt_r - 32'h1;
      end
      port_en_o <= port_en_nxt;
      cts_on_o <= cts_nxt;
      module_active_o <= (state_nxt != UWK_IDLE);
      pwr_state_o <= state_nxt;
    end
  end

  // Inactivity timer counted in frames
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      frame_cnt_r <= 32'h0;
      frames_left_r <= `UWK_RST_TMO;
    end else if (restart_tmo) begin
      frame_cnt_r <= 32'h0;
      frames_left_r <= cfg_tmo_r;
    end else if (active_w && !tmo_done) begin
      if (frame_cnt_r == FRAME_LAST) begin
        frame_cnt_r <= 32'h0;
        frames_left_r <= frames_left_r - 16'h1;
      end else begin
        frame_cnt_r <= frame_cnt_r + 32'h1;
      end
    end
  end

  // Leading-character tracking and discard count
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lead_pend_r <= 1'h1;
      drop_cnt_r <= 8'h00;
    end else begin
      // A line ending arms the discard for the next line's extra character
      if (push_w && rx_data_i == `UWK_CHAR_CR) begin
        lead_pend_r <= 1'h1;
      end else if (enter_act) begin
        // After a wake the wake character itself served as the extra one
        lead_pend_r <= (state_r == UWK_IDLE);
      end else if (take_w && active_w) begin
        lead_pend_r <= 1'h0;
      end
      if (reg_wr_i && sel_drop) begin
        drop_cnt_r <= (take_w && !push_w) ? 8'h01 : 8'h00;
      end else if (take_w && !push_w && drop_cnt_r != 8'hff) begin
        drop_cnt_r <= drop_cnt_r + 8'h01;
      end
    end
  end

  uwk_buf #(
    .W(8)
  ) u_buf (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(push_w),
    .in_data_i(rx_data_i),
    .in_ready_o(rx_ready_o),
    .out_valid_o(dat_valid_o),
    .out_data_o(dat_data_o),
    .out_ready_i(dat_ready_i)
  );

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  chk_no_pass_idle: assert property ((state_r != UWK_ACTIVE) |-> !push_w)
    else $error("character passed while port not active");
  chk_edge_wakes: assert property ((state_r == UWK_IDLE && !hold_on && rise_w)
    |=> state_r == UWK_WAKING ##1 module_active_o)
    else $error("rising edge in idle did not start wake-up");
  chk_wake_done: assert property ((state_r == UWK_WAKING && wake_cnt_r == 32'h0)
    |=> (state_r == UWK_ACTIVE) ##1 port_en_o)
    else $error("wake time elapsed without port enable");
  chk_wake_char_dropped: assert property ($rose(state_r == UWK_WAKING)
    |-> !port_en_o throughout (state_r == UWK_WAKING)[*2])
    else $error("port enabled while still waking");
  chk_wake_hold: assert property ((state_r == UWK_WAKING && wake_cnt_r != 32'h0 && !hold_on)
    |=> state_r == UWK_WAKING && wake_cnt_r == $past(wake_cnt_r) - 32'h1)
    else $error("wake time cut short");
  chk_tmo_idle: assert property ((active_w && tmo_done && !hold_on)
    |=> state_r == UWK_IDLE ##1 !port_en_o)
    else $error("timeout did not return port to idle");
  chk_no_hwfc_rts: assert property (cfg_mode_r == `UWK_MODE_RTS |-> !cfg_hwfc_r)
    else $error("flow control set in RTS-controlled mode");
  chk_cts_follow: assert property ((cfg_mode_r == `UWK_MODE_RTS && !rts_on_i)[*2]
    |-> cts_on_o == port_en_o)
    else $error("CTS does not follow port state");
  chk_abd_lead: assert property ((cfg_abd_r && lead_pend_r && take_w && active_w)
    |-> !push_w ##1 !lead_pend_r || $past(enter_act))
    else $error("leading character not discarded");
  chk_call_port: assert property (call_active_i |=> port_en_o)
    else $error("port disabled during call");
  chk_restart_tmo: assert property ((take_w && active_w)
    |=> frames_left_r == $past(cfg_tmo_r) && frame_cnt_r == 32'h0)
    else $error("received character did not restart timer");
  chk_tmo_range: assert property (cfg_tmo_r >= `UWK_TMO_MIN && cfg_tmo_r <= `UWK_TMO_MAX)
    else $error("timeout outside programmable range");
  chk_drop_count: assert property ((take_w && !push_w && !(reg_wr_i && sel_drop)
    && drop_cnt_r != 8'hff) |=> drop_cnt_r == $past(drop_cnt_r) + 8'h01)
    else $error("discarded character not counted");
  chk_port_state: assert property (port_en_o == (state_r == UWK_ACTIVE))
    else $error("port enable does not match power state");
  chk_module_awake: assert property (module_active_o == (state_r != UWK_IDLE))
    else $error("module activity does not match power state");
  chk_idle_stays: assert property ((state_r == UWK_IDLE && !hold_on && !rise_w)
    |=> state_r == UWK_IDLE)
    else $error("left idle without a wake edge");
  chk_hold_wakes: assert property ((hold_on && state_r != UWK_ACTIVE)
    |=> state_r == UWK_ACTIVE)
    else $error("hold condition did not enable the port");
  chk_cts_fixed: assert property (!cts_follow |=> cts_on_o)
    else $error("CTS not held on outside power-saving control");
  chk_frame_step: assert property ((active_w && !restart_tmo && !tmo_done
    && frame_cnt_r == FRAME_LAST) |=> frames_left_r == $past(frames_left_r) - 16'h1)
    else $error("frame count did not step the timer");
  chk_state_out: assert property (pwr_state_o == state_r)
    else $error("reported power state differs from internal state");
endmodule // uwk_top
`default_nettype wire

// ===== dv/uwk_host.sv
// Host partner model driving the receive line, RTS and the receiver handshake
`default_nettype none
module uwk_host (
  // Clock
  input wire logic mclk_i,
  // Toward the block
  output logic rxd_o,
  output logic rts_on_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  input wire logic rx_ready_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rxd_o = 1'b1;
    rts_on_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
  end
  // Host raises or drops RTS at the next edge; dropping it allows power saving
  task automatic rts(input logic v);
    @(posedge mclk_i);
    rts_on_o <= v;
  endtask
  // Start bit then the rising edge; the character is offered until taken or given up
  task automatic send(input logic [7:0] d, output bit ok);
    int n;
    ok = 1'b0;
    @(posedge mclk_i);
    rxd_o <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rxd_o <= 1'b1;
    rx_valid_o <= 1'b1;
    rx_data_o <= d;
    for (n = 0; n < 50 && !ok; n++) begin
      @(posedge mclk_i);
      ok = rx_ready_i;
    end
    rx_valid_o <= 1'b0;
    // Released data never keeps the old value, so a stale sample cannot pass
    rx_data_o <= ~d;
  endtask
endmodule // uwk_host
`default_nettype wire

// ===== dv/test_uwk_top.sv
// Self-checking bench of the wake-up block with a queue model of delivered characters
`default_nettype none
module test_uwk_top;
  timeunit 1ns;
  timeprecision 1ps;
  import uwk_pkg::*;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic dat_ready_i = 1'b1;
  logic call_active_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic rxd_i, rts_on_i, cts_on_o, rx_valid_i, rx_ready_o;
  logic dat_valid_o, port_en_o, module_active_o;
  logic [7:0] rx_data_i, dat_data_o;
  uwk_state_t pwr_state_o;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int drops = 0;
  logic [16:0] seed = 17'd89671;
  logic [7:0] exp_q[$];
  always #2.5 mclk_i = ~mclk_i;
  // Short frame and wake counts keep the run small
  uwk_top #(.FRAME_CYC(4), .WAKE_CYC(3)) dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rxd_i(rxd_i), .rts_on_i(rts_on_i),
    .cts_on_o(cts_on_o), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
    .rx_ready_o(rx_ready_o), .dat_valid_o(dat_valid_o), .dat_data_o(dat_data_o),
    .dat_ready_i(dat_ready_i), .call_active_i(call_active_i), .port_en_o(port_en_o),
    .module_active_o(module_active_o), .pwr_state_o(pwr_state_o));
  uwk_host host (.mclk_i(mclk_i), .rxd_o(rxd_i), .rts_on_o(rts_on_i),
    .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_ready_i(rx_ready_o));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] rnd();
    seed = {seed[15:0], seed[16] ^ seed[13]};
    // High bit set so a random character is never the line end
    return seed[7:0] | 8'h80;
  endfunction
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= w;
    reg_rd_i <= !w;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    // Read data stand only until the next edge, so take them once they have settled
    #1;
    q = reg_rdata_o;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic put(input logic [7:0] d, input bit dlv);
    bit ok;
    host.send(d, ok);
    chk(32'(ok), 32'h1);
    if (dlv) exp_q.push_back(d);
    else drops++;
  endtask
  task automatic wt(input uwk_state_t s, input int lim, output int n);
    n = 0;
    while (pwr_state_o !== s && n < lim) begin
      @(posedge mclk_i);
      n++;
    end
    chk(32'(pwr_state_o), 32'(s));
  endtask
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      err_count++;
      give_verdict();
    end
    if (dat_valid_o === 1'b1 && dat_ready_i === 1'b1) begin
      chk(32'(dat_data_o), exp_q.size() > 0 ? 32'(exp_q.pop_front()) : 32'hdead);
    end
  end
  initial begin
    int n;
    bit ok;
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rc(8'h08, 32'he);
    rc(8'h04, 32'h7d0);
    rc(8'h10, 32'h0);
    wr(8'h04, 32'h5);
    rc(8'h04, 32'h28);
    wr(8'h04, 32'hffff);
    rc(8'h04, 32'hfde8);
    wr(8'h00, 32'h6);
    rc(8'h00, 32'h2);
    wr(8'h00, 32'h3);
    rc(8'h00, 32'h2);
    wr(8'h04, 32'd40);
    wr(8'h00, 32'h1);
    put(8'h41, 1'b1);
    wt(UWK_IDLE, 400, n);
    chk(32'(n >= 150 && n <= 175), 32'h1);
    @(posedge mclk_i);
    chk(32'(port_en_o), 32'h0);
    wr(8'h0c, 32'h0);
    drops = 0;
    // Autobaud on: wake char lost, line end passed, next leading char dropped
    wr(8'h00, 32'h9);
    put(8'h55, 1'b0);
    wt(UWK_WAKING, 10, n);
    chk(32'(module_active_o), 32'h1);
    chk(32'(port_en_o), 32'h0);
    wt(UWK_ACTIVE, 10, n);
    @(posedge mclk_i);
    chk(32'(port_en_o), 32'h1);
    put(8'h0d, 1'b1);
    put(8'h55, 1'b0);
    put(rnd(), 1'b1);
    rc(8'h0c, 32'(drops));
    dat_ready_i <= 1'b0;
    put(rnd(), 1'b1);
    put(rnd(), 1'b1);
    host.send(8'h99, ok);
    chk(32'(ok), 32'h0);
    dat_ready_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    chk(32'(exp_q.size()), 32'h0);
    put(rnd(), 1'b1);
    wr(8'h00, 32'h2);
    host.rts(1'b1);
    repeat (3) @(posedge mclk_i);
    chk(32'(cts_on_o), 32'h1);
    host.rts(1'b0);
    wt(UWK_IDLE, 400, n);
    repeat (2) @(posedge mclk_i);
    chk(32'(cts_on_o), 32'h0);
    call_active_i <= 1'b1;
    wt(UWK_ACTIVE, 4, n);
    repeat (2) @(posedge mclk_i);
    rc(8'h08, 32'h2e);
    call_active_i <= 1'b0;
    give_verdict();
  end
endmodule // test_uwk_top
`default_nettype wire
